// ---- logic/icc_pkg.sv ----
// package: register map, field layout, reset values and timing for the impedance channel config block
package icc_pkg;
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 24;
    // register offsets
    localparam logic [7:0]  CFG_OFFSET          = 8'h18;
    localparam logic [7:0]  GEN_OFFSET          = 8'h10;
    localparam logic [7:0]  IRQ_STATUS_OFFSET   = 8'h01;
    localparam logic [7:0]  IRQ_MASK_OFFSET     = 8'h02;
    localparam logic [7:0]  FAULT_OFFSET        = 8'h03;
    // field positions of the channel config word
    localparam int          RATE_BIT            = 23;
    localparam int          ANALOG_HIGHPASS_CUTOFF_LSB            = 20;
    localparam int          BIAS_BIT            = 19;
    localparam int          LNOISE_BIT          = 18;
    localparam int          GAIN_LSB            = 16;
    localparam int          DIGITAL_HIGHPASS_CUTOFF_LSB            = 14;
    localparam int          DIGITAL_LOWPASS_CUTOFF_LSB            = 12;
    localparam int          FREQ_LSB            = 8;
    localparam int          MON_BIT             = 7;
    localparam int          MAG_LSB             = 4;
    localparam int          PHASE_LSB           = 0;
    // field positions of the general word
    localparam int          MCLK_LSB            = 20;
    // reset values
    localparam logic [23:0] CFG_RESET           = 24'h201800;
    localparam logic [1:0]  MCLK_RESET          = 2'h0;
    localparam logic [1:0]  DIGITAL_LOWPASS_CUTOFF_FALLBACK       = 2'h1;
    localparam logic [1:0]  DIGITAL_LOWPASS_CUTOFF_16HZ           = 2'h3;
    // interrupt status bits
    localparam int          IRQ_FAULT_BIT       = 0;
    localparam int          IRQ_SAMPLE_BIT      = 1;
    localparam int          IRQ_W               = 2;
    // master clock rates in hertz per selection
    localparam int          MCLK_HZ_0           = 32768;
    localparam int          MCLK_HZ_1           = 32000;
    localparam int          MCLK_HZ_2           = 32000;
    localparam int          MCLK_HZ_3           = 31968;
    localparam int          SYS_CLK_HZ          = 20000000;
    // master clock ticks per sample at the fast rate (49.95 sps at 31968 Hz)
    localparam int          SAMPLE_DIV_FAST_0   = 512;
    localparam int          SAMPLE_DIV_FAST_1   = 512;
    localparam int          SAMPLE_DIV_FAST_2   = 640;
    localparam int          SAMPLE_DIV_FAST_3   = 640;
    localparam int          CNT_W               = 12;
    // phase step sizes in hundredths of a degree
    localparam int          PHASE_STEP_FINE     = 1125;
    localparam int          PHASE_STEP_MID      = 2250;
    localparam int          PHASE_STEP_COARSE   = 4500;
    localparam int          PHASE_W             = 15;
    typedef enum logic [1:0] {
        MCLK_32768 = 2'b00,
        MCLK_32000 = 2'b01,
        MCLK_32000_B = 2'b10,
        MCLK_31968 = 2'b11
    } icc_mclk_t;
endpackage

// ---- logic/icc_tick_gen.sv ----
// master clock tick divider and sample strobe generator
`timescale 1ns/1ns
module icc_tick_gen
    import icc_pkg::*;
#(
    parameter int CNT_WIDTH = icc_pkg::CNT_W
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mclk_sel,
    input  wire logic       rate_slow,
    output logic            mclk_tick,
    output logic            sample_tick
);
    // ---------------------------------------------------------------
    // master clock tick
    // ---------------------------------------------------------------
    // fractional accumulator: exact long term rate, jitter of one cycle
    logic [24:0] acc_q;
    logic [24:0] inc;
    logic [CNT_WIDTH-1:0] div;
    logic [CNT_WIDTH-1:0] cnt_q;

    always_comb begin
        case (mclk_sel)
            2'b00:   inc = 25'(MCLK_HZ_0);
            2'b01:   inc = 25'(MCLK_HZ_1);
            2'b10:   inc = 25'(MCLK_HZ_2);
            default: inc = 25'(MCLK_HZ_3);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q     <= '0;
            mclk_tick <= 1'b0;
        end else if (acc_q + inc >= 25'(SYS_CLK_HZ)) begin
            acc_q     <= 25'(acc_q + inc - 25'(SYS_CLK_HZ));
            mclk_tick <= 1'b1;
        end else begin
            acc_q     <= 25'(acc_q + inc);
            mclk_tick <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // sample strobe
    // ---------------------------------------------------------------
    always_comb begin
        case (mclk_sel)
            2'b00:   div = CNT_WIDTH'(SAMPLE_DIV_FAST_0);
            2'b01:   div = CNT_WIDTH'(SAMPLE_DIV_FAST_1);
            2'b10:   div = CNT_WIDTH'(SAMPLE_DIV_FAST_2);
            default: div = CNT_WIDTH'(SAMPLE_DIV_FAST_3);
        endcase
        if (rate_slow) begin
            div = CNT_WIDTH'({div, 1'b0});
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q       <= '0;
            sample_tick <= 1'b0;
        end else if (mclk_tick && cnt_q >= CNT_WIDTH'(div - 1'b1)) begin
            cnt_q       <= '0;
            sample_tick <= 1'b1;
        end else begin
            if (mclk_tick) begin
                cnt_q <= CNT_WIDTH'(cnt_q + 1'b1);
            end
            sample_tick <= 1'b0;
        end
    end
endmodule

// ---- logic/icc_top.sv ----
// impedance channel configuration register bank with derived channel controls
`timescale 1ns/1ns
module icc_top
    import icc_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic [icc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [icc_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [icc_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        compliance_fault_in,
    output logic                             irq,
    output logic                             sample_strobe,
    output logic      [2:0]                  analog_highpass_cutoff,
    output logic                             analog_highpass_bypass,
    output logic                             external_bias_select,
    output logic                             amp_low_noise_select,
    output logic      [1:0]                  gain_select,
    output logic      [1:0]                  digital_highpass_cutoff,
    output logic      [1:0]                  digital_lowpass_cutoff,
    output logic      [7:0]                  drive_mod_divider,
    output logic                             drive_mod_multiply,
    output logic                             drive_compliance_monitor_enable,
    output logic      [2:0]                  drive_current_magnitude,
    output logic                             drive_enable,
    output logic      [icc_pkg::PHASE_W-1:0] drive_phase_offset,
    output logic                             drive_compliance_fault_flag
);
    import icc_pkg::*;

    // ---------------------------------------------------------------
    // stored registers
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] cfg_q;
    logic [1:0]        mclk_q;
    logic [IRQ_W-1:0]  irq_status_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              fault_s1_q;
    logic              fault_s2_q;
    logic              mclk_tick;
    logic              sample_tick;
    logic [1:0]        digital_lowpass_cutoff_eff;
    logic [DATA_W-1:0] cfg_view;
    logic [3:0]        freq;
    logic [3:0]        phase;
    logic              wr_cfg;
    logic              wr_gen;
    logic              wr_mask;
    logic              rd_status;
    logic              fault_event;

    assign wr_cfg    = reg_wr && reg_addr == CFG_OFFSET;
    assign wr_gen    = reg_wr && reg_addr == GEN_OFFSET;
    assign wr_mask   = reg_wr && reg_addr == IRQ_MASK_OFFSET;
    assign rd_status = reg_rd && reg_addr == IRQ_STATUS_OFFSET;
    assign freq      = cfg_q[FREQ_LSB+:4];
    assign phase     = cfg_q[PHASE_LSB+:4];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mclk_q <= MCLK_RESET;
        end else if (wr_gen) begin
            mclk_q <= reg_wdata[MCLK_LSB+:2];
        end
    end

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    icc_tick_gen #(
        .CNT_WIDTH (CNT_W)
    ) u_tick (
        .clk         (clk),
        .rst_n       (rst_n),
        .mclk_sel    (mclk_q),
        .rate_slow   (cfg_q[RATE_BIT]),
        .mclk_tick   (mclk_tick),
        .sample_tick (sample_tick)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= sample_tick;
        end
    end

    // ---------------------------------------------------------------
    // effective low pass code
    // ---------------------------------------------------------------
    // 16 hz only exists at the fast rate; every master clock choice has one
    always_comb begin
        digital_lowpass_cutoff_eff = cfg_q[DIGITAL_LOWPASS_CUTOFF_LSB+:2];
        if (cfg_q[RATE_BIT] && digital_lowpass_cutoff_eff == DIGITAL_LOWPASS_CUTOFF_16HZ) begin
            digital_lowpass_cutoff_eff = DIGITAL_LOWPASS_CUTOFF_FALLBACK;
        end
    end

    always_comb begin
        cfg_view                 = cfg_q;
        cfg_view[DIGITAL_LOWPASS_CUTOFF_LSB+:2]    = digital_lowpass_cutoff_eff;
    end

    // ---------------------------------------------------------------
    // channel controls
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analog_highpass_cutoff <= CFG_RESET[ANALOG_HIGHPASS_CUTOFF_LSB+:3];
            analog_highpass_bypass <= 1'b0;
            external_bias_select   <= 1'b0;
            amp_low_noise_select   <= 1'b0;
            gain_select            <= 2'h0;
            digital_highpass_cutoff <= 2'h0;
            digital_lowpass_cutoff <= CFG_RESET[DIGITAL_LOWPASS_CUTOFF_LSB+:2];
        end else begin
            analog_highpass_cutoff <= cfg_q[ANALOG_HIGHPASS_CUTOFF_LSB+:3];
            analog_highpass_bypass <= cfg_q[ANALOG_HIGHPASS_CUTOFF_LSB+2] & cfg_q[ANALOG_HIGHPASS_CUTOFF_LSB+1];
            external_bias_select   <= cfg_q[BIAS_BIT];
            amp_low_noise_select   <= cfg_q[LNOISE_BIT];
            gain_select            <= cfg_q[GAIN_LSB+:2];
            // 1x collapses to one code so downstream sees a single 0.50 hz setting
            digital_highpass_cutoff <= cfg_q[DIGITAL_HIGHPASS_CUTOFF_LSB+1] ? 2'h2 : cfg_q[DIGITAL_HIGHPASS_CUTOFF_LSB+:2];
            digital_lowpass_cutoff <= digital_lowpass_cutoff_eff;
        end
    end

    // ---------------------------------------------------------------
    // drive generator controls
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_mod_divider  <= 8'h40;
            drive_mod_multiply <= 1'b0;
        end else begin
            drive_mod_multiply <= 1'b0;
            case (freq)
                4'h0: begin
                    drive_mod_divider  <= 8'h04;
                    drive_mod_multiply <= 1'b1;
                end
                4'h1: begin
                    drive_mod_divider  <= 8'h02;
                    drive_mod_multiply <= 1'b1;
                end
                4'h2: drive_mod_divider <= 8'h01;
                4'h3: drive_mod_divider <= 8'h02;
                4'h4: drive_mod_divider <= 8'h04;
                4'h5: drive_mod_divider <= 8'h08;
                4'h6: drive_mod_divider <= 8'h10;
                4'h7: drive_mod_divider <= 8'h20;
                4'h8: drive_mod_divider <= 8'h40;
                4'h9: drive_mod_divider <= 8'h80;
                // 256 does not fit eight bits; zero stands for it
                default: drive_mod_divider <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_phase_offset <= '0;
        end else if (freq >= 4'h2) begin
            drive_phase_offset <= PHASE_W'(phase * PHASE_STEP_FINE);
        end else if (freq == 4'h1) begin
            drive_phase_offset <= PHASE_W'(phase[3:1] * PHASE_STEP_MID);
        end else begin
            drive_phase_offset <= PHASE_W'(phase[3:2] * PHASE_STEP_COARSE);
        end
    end

    // magnitude 110 and rate limits are left to software; code passes as written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_current_magnitude         <= 3'h0;
            drive_enable                    <= 1'b0;
            drive_compliance_monitor_enable <= 1'b0;
        end else begin
            drive_current_magnitude         <= cfg_q[MAG_LSB+:3];
            drive_enable                    <= cfg_q[MAG_LSB+:3] != 3'h0;
            drive_compliance_monitor_enable <= cfg_q[MON_BIT] && cfg_q[MAG_LSB+:3] != 3'h0;
        end
    end

    // ---------------------------------------------------------------
    // compliance fault and interrupts
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_s1_q <= 1'b0;
            fault_s2_q <= 1'b0;
        end else begin
            fault_s1_q <= compliance_fault_in;
            fault_s2_q <= fault_s1_q;
        end
    end

    assign fault_event = fault_s2_q && drive_compliance_monitor_enable;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_compliance_fault_flag <= 1'b0;
        end else begin
            drive_compliance_fault_flag <= fault_event;
        end
    end

    // set beats the read clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (rd_status ? '0 : irq_status_q)
                          | {sample_tick, fault_event};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_mask_q <= '0;
        end else if (wr_mask) begin
            irq_mask_q <= reg_wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((rd_status ? '0 : irq_status_q) | {sample_tick, fault_event}) & irq_mask_q);
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                CFG_OFFSET:        reg_rdata <= cfg_view;
                GEN_OFFSET:        reg_rdata <= DATA_W'({mclk_q, 20'h00000});
                IRQ_STATUS_OFFSET: reg_rdata <= DATA_W'(irq_status_q);
                IRQ_MASK_OFFSET:   reg_rdata <= DATA_W'(irq_mask_q);
                FAULT_OFFSET:      reg_rdata <= DATA_W'(fault_event);
                default:           reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// ---- tb/icc_fault_src.sv ----
// far-side model: analog compliance monitor driving its fault level
`timescale 1ns/1ns
module icc_fault_src (
    input  wire logic fault_req,
    output logic      fault_out
);
    // ---------------------------------------------
    // level output
    // ---------------------------------------------
    // the analog monitor knows nothing of clk, so its edges land mid-cycle
    initial fault_out = 1'b0;
    always @(fault_req) begin
        fault_out <= #17 fault_req;
    end
endmodule

// ---- tb/icc_properties.sv ----
// concurrent checks on the ports of the impedance channel config block
`timescale 1ns/1ns
module icc_properties
    import icc_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic [icc_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [icc_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [icc_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic                        sample_strobe,
    input wire logic [2:0]                  analog_highpass_cutoff,
    input wire logic                        analog_highpass_bypass,
    input wire logic                        external_bias_select,
    input wire logic                        amp_low_noise_select,
    input wire logic [1:0]                  gain_select,
    input wire logic [1:0]                  digital_highpass_cutoff,
    input wire logic [7:0]                  drive_mod_divider,
    input wire logic                        drive_mod_multiply,
    input wire logic                        drive_compliance_monitor_enable,
    input wire logic [2:0]                  drive_current_magnitude,
    input wire logic                        drive_enable,
    input wire logic [icc_pkg::PHASE_W-1:0] drive_phase_offset,
    input wire logic                        drive_compliance_fault_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    a_wr_fields: assert property (reg_wr && reg_addr == CFG_OFFSET |-> ##2
        {external_bias_select, amp_low_noise_select, gain_select} == $past(reg_wdata[19:16], 2))
        else $error("field outputs wrong");
    a_wr_magnitude: assert property (reg_wr && reg_addr == CFG_OFFSET |-> ##2
        drive_current_magnitude == $past(reg_wdata[6:4], 2) && drive_enable == ($past(reg_wdata[6:4], 2) != 3'h0))
        else $error("magnitude wrong");
    a_bypass_code: assert property (analog_highpass_bypass == (analog_highpass_cutoff[2:1] == 2'h3))
        else $error("bypass mismatch");
    a_mon_needs_drive: assert property (drive_compliance_monitor_enable |-> drive_enable)
        else $error("monitor without drive");
    a_fault_needs_mon: assert property (drive_compliance_fault_flag |-> $past(drive_compliance_monitor_enable))
        else $error("fault flag while monitor off");
    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 24'h0) else $error("read data outside slot");
    a_unmapped_read: assert property ($past(reg_rd) && !($past(reg_addr) inside {8'h18, 8'h10, 8'h01, 8'h02, 8'h03})
        |-> reg_rdata == 24'h0) else $error("unmapped read not zero");
    a_mult_codes: assert property (drive_mod_multiply |-> drive_mod_divider inside {8'h2, 8'h4})
        else $error("multiply code wrong");
    a_phase_grid: assert property (drive_mod_multiply && drive_mod_divider == 8'h4
        |-> drive_phase_offset % 4500 == 0) else $error("coarse phase off grid");
    a_digital_lowpass_cutoff_read: assert property ($past(reg_rd) && $past(reg_addr) == CFG_OFFSET && reg_rdata[23]
        |-> reg_rdata[13:12] != 2'h3) else $error("unsupported low pass read back");
    a_digital_highpass_cutoff_code: assert property (digital_highpass_cutoff != 2'h3) else $error("high pass code 11 out");
    a_sample_pulse: assert property (sample_strobe |=> !sample_strobe) else $error("sample strobe too long");
endmodule

// ---- tb/test_impedance_channel_config.sv ----
// self-checking testbench for the impedance channel config block
`timescale 1ns/1ns
module test_impedance_channel_config;
    import icc_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, fault_req, fault_in, irq, sample_strobe, ahp_byp, bias, lnoise;
    logic drv_mult, mon_en, drv_en, fault_flag;
    logic [7:0]  reg_addr, drv_div;
    logic [23:0] reg_wdata, reg_rdata, w;
    logic [2:0]  ahp, mag, cm;
    logic [1:0]  gain, dhp, dlp, eff;
    logic [14:0] phase;
    logic [4:0]  i, f;
    int          n_mismatch, num_checks;
    icc_top icc_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compliance_fault_in(fault_in), .irq(irq),
        .sample_strobe(sample_strobe), .analog_highpass_cutoff(ahp), .analog_highpass_bypass(ahp_byp),
        .external_bias_select(bias), .amp_low_noise_select(lnoise), .gain_select(gain),
        .digital_highpass_cutoff(dhp), .digital_lowpass_cutoff(dlp), .drive_mod_divider(drv_div),
        .drive_mod_multiply(drv_mult), .drive_compliance_monitor_enable(mon_en),
        .drive_current_magnitude(mag), .drive_enable(drv_en), .drive_phase_offset(phase),
        .drive_compliance_fault_flag(fault_flag));
    icc_fault_src icc_fault_src_i (.fault_req(fault_req), .fault_out(fault_in));
    // ---------------------------------------------
    // bus tasks and checks
    // ---------------------------------------------
    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp, input logic [23:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, exp);
    endtask
    // outputs follow one cycle after the stored word changes
    task automatic cfg(input logic [23:0] d);
        wr(CFG_OFFSET, d);
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 12 && irq !== 1'b1; n++) @(negedge clk);
        if (irq !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, fault_req, reg_addr, reg_wdata} = '0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({3'h0, sample_strobe, irq, ahp, dlp, drv_div, gain, mag, drv_en},
            {3'h0, 2'h0, 3'h2, 2'h1, 8'h40, 2'h0, 3'h0, 1'b0});
        rd_chk(CFG_OFFSET, 24'h201800, 24'hffffff);
        rd_chk(8'h7f, 24'h0, 24'hffffff);
        wr(8'h7f, 24'hffffff);
        rd_chk(CFG_OFFSET, 24'h201800, 24'hffffff);
        for (i = 0; i < 8; i++) begin
            cm = (i == 5'd6) ? 3'h7 : i[2:0];
            w = {1'b0, i[2:0], i[0], i[1], i[1:0], i[1:0], i[1:0], 4'h8, i[0], cm, 4'h0};
            cfg(w);
            chk({7'h0, ahp, ahp_byp, bias, lnoise, gain, dhp, dlp, drv_en, mon_en}, {7'h0, i[2:0], i[2] & i[1],
                i[0], i[1], i[1:0], i[1], i[1] ? 1'b0 : i[0], i[1:0], (cm != 3'h0), i[0]});
            chk({21'h0, mag}, {21'h0, w[6:4]});
            rd_chk(CFG_OFFSET, w, 24'hffffff);
        end
        for (f = 0; f < 16; f++) begin
            w = {12'h201, f[3:0], 4'h1, f[3:0] ^ 4'ha};
            cfg(w);
            chk({drv_mult, drv_div, phase}, {f < 2, (f == 0) ? 8'h4 : (f == 1) ? 8'h2 : (f > 9) ? 8'h0
                : 8'h1 << (f - 2), (f > 1) ? 15'(w[3:0] * 1125) : (f == 1) ? 15'(w[3:1] * 2250)
                : 15'(w[3:2] * 4500)});
        end
        wr(GEN_OFFSET, 24'h300000);
        rd_chk(GEN_OFFSET, 24'h300000, 24'hffffff);
        for (i = 0; i < 8; i++) begin
            w = {i[2], 9'h004, i[1:0], 12'h800};
            eff = (i[2] && i[1:0] == 2'h3) ? 2'h1 : i[1:0];
            cfg(w);
            chk({22'h0, dlp}, {22'h0, eff});
            rd_chk(CFG_OFFSET, {w[23:14], eff, w[11:0]}, 24'hffffff);
        end
        // interrupt: unmasked fault, clear on read, then masked, then monitor off
        wr(IRQ_MASK_OFFSET, 24'h1);
        cfg(24'h201890);
        fault_req <= 1'b1;
        wait_irq();
        chk({23'h0, fault_flag}, 24'h1);
        rd_chk(FAULT_OFFSET, 24'h1, 24'h1);
        fault_req <= 1'b0;
        settle();
        rd_chk(IRQ_STATUS_OFFSET, 24'h1, 24'h1);
        rd_chk(IRQ_STATUS_OFFSET, 24'h0, 24'h1);
        settle();
        chk({23'h0, irq}, 24'h0);
        wr(IRQ_MASK_OFFSET, 24'h0);
        fault_req <= 1'b1;
        settle();
        chk({23'h0, irq}, 24'h0);
        fault_req <= 1'b0;
        settle();
        rd_chk(IRQ_STATUS_OFFSET, 24'h1, 24'h1);
        cfg(24'h201810);
        fault_req <= 1'b1;
        settle();
        chk({22'h0, fault_flag, mon_en}, 24'h0);
        fault_req <= 1'b0;
        settle();
        rd_chk(IRQ_STATUS_OFFSET, 24'h0, 24'h1);
        test_done();
    end
endmodule

bind icc_top icc_properties icc_properties_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
    .analog_highpass_cutoff(analog_highpass_cutoff), .analog_highpass_bypass(analog_highpass_bypass),
    .external_bias_select(external_bias_select), .amp_low_noise_select(amp_low_noise_select),
    .gain_select(gain_select), .digital_highpass_cutoff(digital_highpass_cutoff),
    .drive_mod_divider(drive_mod_divider), .drive_mod_multiply(drive_mod_multiply),
    .drive_compliance_monitor_enable(drive_compliance_monitor_enable),
    .drive_current_magnitude(drive_current_magnitude), .drive_enable(drive_enable),
    .drive_phase_offset(drive_phase_offset), .drive_compliance_fault_flag(drive_compliance_fault_flag));
